// ===== core/alcpl_pkg.sv
// Purpose: Shared constants, types and tables for the record-path gain controller
// Assumes: Register word index times four gives the byte address
// Notes:   Timing units are ticks of 1/96000 s, advanced per input sample
package alcpl_pkg;

   // -----------------------------------------------------------------
   // Register indices and reset values
   // -----------------------------------------------------------------
   localparam logic [7:0]  IDX_CFG1 = 8'h20;
   localparam logic [7:0]  IDX_CFG2 = 8'h21;
   localparam logic [7:0]  IDX_CFG3 = 8'h22;
   localparam logic [7:0]  IDX_CFG4 = 8'h23;
   localparam logic [7:0]  IDX_STAT = 8'h24;
   localparam logic [8:0]  CFG1_RST = 9'h038;
   localparam logic [8:0]  CFG2_RST = 9'h00b;
   localparam logic [8:0]  CFG3_RST = 9'h032;
   localparam logic [13:0] CFG4_RST = 14'h1000;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int EN_BIT     = 8;
   localparam int MAX_LSB    = 3;
   localparam int MIN_LSB    = 0;
   localparam int ZC_BIT     = 8;
   localparam int HOLD_LSB   = 4;
   localparam int LVL_LSB    = 0;
   localparam int MODE_BIT   = 8;
   localparam int DCY_LSB    = 4;
   localparam int ATK_LSB    = 0;
   localparam int SR_LSB     = 0;
   localparam int STATIC_LSB = 8;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int TICKS_PER_S   = 96000;
   localparam int HOLD_BASE_NS  = 2670000;
   localparam int ATK_STEP_NS   = 104000;
   localparam int DCY_STEP_NS   = 410000;
   localparam logic [23:0] HOLD_TICKS =
      24'((HOLD_BASE_NS * (TICKS_PER_S / 1000) + 999999) / 1000000);
   localparam logic [23:0] ATK_TICKS =
      24'((ATK_STEP_NS * (TICKS_PER_S / 1000) + 999999) / 1000000);
   localparam logic [23:0] DCY_TICKS =
      24'((DCY_STEP_NS * (TICKS_PER_S / 1000) + 999999) / 1000000);
   localparam logic [3:0]  MAX_RATE_CODE = 4'ha;
   localparam int          LIM_SHIFT     = 2;
   localparam logic [23:0] ACC_MAX       = 24'hffffff;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE   = 2'h0,
      ST_ATTACK = 2'h1,
      ST_HOLD   = 2'h3,
      ST_DECAY  = 2'h2
   } alcpl_state_e_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } alcpl_sample_t;

   typedef struct packed {
      logic [8:0]     cfg1;
      logic [8:0]     cfg2;
      logic [8:0]     cfg3;
      logic [13:0]    cfg4;
      alcpl_state_e_t state;
      logic [5:0]     gain;
      logic [23:0]    acc;
      logic [23:0]    hold_acc;
      logic           pend_up;
      logic           pend_dn;
      logic           last_sign;
      logic           awready;
      logic           wready;
      logic           arready;
      logic           aw_held;
      logic           w_held;
      logic [7:0]     aw_idx;
      logic [15:0]    w_data;
      logic [1:0]     w_strb;
      logic           bvalid;
      logic [1:0]     bresp;
      logic           rvalid;
      logic [31:0]    rdata;
      logic [1:0]     rresp;
   } alcpl_regs_t;

   // -----------------------------------------------------------------
   // Tables
   // -----------------------------------------------------------------
   function automatic logic [3:0] sr_weight(input logic [2:0] code);
      unique case (code)
         3'h0:    sr_weight = 4'h2;
         3'h1:    sr_weight = 4'h3;
         3'h2:    sr_weight = 4'h4;
         3'h3:    sr_weight = 4'h6;
         3'h4:    sr_weight = 4'h8;
         3'h5:    sr_weight = 4'hc;
         default: sr_weight = 4'h2;
      endcase
   endfunction : sr_weight

   function automatic logic [15:0] level_thr(input logic [3:0] code);
      unique case (code)
         4'h0: level_thr = 16'h04d0;
         4'h1: level_thr = 16'h05b8;
         4'h2: level_thr = 16'h06cc;
         4'h3: level_thr = 16'h0814;
         4'h4: level_thr = 16'h0999;
         4'h5: level_thr = 16'h0b68;
         4'h6: level_thr = 16'h0d8f;
         4'h7: level_thr = 16'h101d;
         4'h8: level_thr = 16'h1326;
         4'h9: level_thr = 16'h16c3;
         4'ha: level_thr = 16'h1b0d;
         4'hb: level_thr = 16'h2027;
         4'hc: level_thr = 16'h2636;
         4'hd: level_thr = 16'h2d6b;
         4'he: level_thr = 16'h35fa;
         4'hf: level_thr = 16'h4027;
      endcase
   endfunction : level_thr

endpackage : alcpl_pkg

// ===== core/alcpl_core.sv
// Purpose: Record-path automatic gain control and peak limiter with AXI4-Lite registers
// Assumes: Samples arrive on aclk as one-cycle valid pulses
// Notes:   Gain code is 0.75 dB per step, code 0 is -12 dB
`timescale 1ns/1ps

// Function
// RQ1: Limiter mode ramps gain down when sample peaks exceed the threshold.
// RQ2: Limiter mode restores gain slowly, never above the static gain.
// RQ3: Level mode keeps the ADC level constant by adjusting gain both ways.
// RQ4: Gain control runs only while enable bit 8 is set; off at reset.
// RQ5: Controlled gain stays between programmed ceiling and floor.
// RQ6: Ceiling field bits 5:3, 6 dB steps, -6.75 to +35.25 dB, reset 111.
// RQ7: Floor field bits 2:0, 6 dB steps, -12 to +30 dB, reset 000.
// RQ8: Hold field bits 7:4 delays ramp-up; 0 none, then doubling from 2.67 ms.
// RQ9: Limiter mode ignores the hold delay.
// RQ10: Hold only delays increases; reduction starts immediately above target.
// RQ11: Target field bits 3:0 sets level, -28.5 to -6 dBFS, reset 1011.
// RQ12: Level-mode ramp-up interval doubles per code, 3.3 ms to 3.36 s per 6 dB.
// RQ13: Level-mode ramp-down interval doubles per code, 832 us to 852 ms per 6 dB.
// RQ14: Limiter mode steps about four times faster for the same codes.
// RQ15: Software sets the sample-rate code to match the real rate.
// RQ16: With bit 8 of the second register, gain changes only at zero crossings.
// RQ17: Each change is one step, spaced by the selected attack or decay interval.
module alcpl_core #(
   parameter int AXI_ADDR_W = 12
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [AXI_ADDR_W-1:0]  awaddr,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   input  wire logic [AXI_ADDR_W-1:0]  araddr,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [31:0]                 rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   input  wire alcpl_pkg::alcpl_sample_t smp,
   output logic [5:0]                  gain_code
);

   if (AXI_ADDR_W < 10) begin : g_chk
      $error("AXI_ADDR_W must be at least 10");
   end

   alcpl_pkg::alcpl_regs_t st;
   alcpl_pkg::alcpl_regs_t next_st;

   // -----------------------------------------------------------------
   // Decoded controls
   // -----------------------------------------------------------------
   logic        gain_ctrl_enable;
   logic        limiter_mode_select;
   logic        zero_cross_update;
   logic [5:0]  gain_ceiling;
   logic [5:0]  gain_floor;
   logic [5:0]  static_gain;
   logic [5:0]  gain_top;
   logic [3:0]  hold_time;
   logic [3:0]  ramp_up_rate;
   logic [3:0]  ramp_down_rate;
   logic [23:0] hold_len;
   logic [23:0] atk_len;
   logic [23:0] dcy_len;
   logic [15:0] abs_val;
   logic [15:0] thr;
   logic        above;
   logic        zc;
   logic [23:0] weight;
   logic [23:0] acc_inc;
   logic [23:0] hold_inc;

   assign gain_ctrl_enable    = st.cfg1[alcpl_pkg::EN_BIT];                   // RQ4
   assign gain_ceiling        = {st.cfg1[alcpl_pkg::MAX_LSB +: 3], 3'h7};      // RQ6
   assign gain_floor          = {st.cfg1[alcpl_pkg::MIN_LSB +: 3], 3'h0};      // RQ7
   assign zero_cross_update   = st.cfg2[alcpl_pkg::ZC_BIT];
   assign hold_time           = st.cfg2[alcpl_pkg::HOLD_LSB +: 4];
   assign limiter_mode_select = st.cfg3[alcpl_pkg::MODE_BIT];
   assign static_gain         = st.cfg4[alcpl_pkg::STATIC_LSB +: 6];
   assign gain_top = (limiter_mode_select && static_gain < gain_ceiling) ?
                     static_gain : gain_ceiling;                              // RQ2
   assign ramp_up_rate   = (st.cfg3[alcpl_pkg::DCY_LSB +: 4] > alcpl_pkg::MAX_RATE_CODE) ?
                           alcpl_pkg::MAX_RATE_CODE : st.cfg3[alcpl_pkg::DCY_LSB +: 4];
   assign ramp_down_rate = (st.cfg3[alcpl_pkg::ATK_LSB +: 4] > alcpl_pkg::MAX_RATE_CODE) ?
                           alcpl_pkg::MAX_RATE_CODE : st.cfg3[alcpl_pkg::ATK_LSB +: 4];
   assign hold_len = (hold_time == 4'h0) ? 24'h0 :
                     (alcpl_pkg::HOLD_TICKS << (hold_time - 4'h1));           // RQ8
   assign dcy_len  = (alcpl_pkg::DCY_TICKS << ramp_up_rate) >>
                     (limiter_mode_select ? alcpl_pkg::LIM_SHIFT : 0);        // RQ12
   assign atk_len  = (alcpl_pkg::ATK_TICKS << ramp_down_rate) >>
                     (limiter_mode_select ? alcpl_pkg::LIM_SHIFT : 0);        // RQ14

   // -----------------------------------------------------------------
   // Peak detection and sample-rate scaled time base
   // -----------------------------------------------------------------
   assign abs_val  = smp.data[15] ? (~smp.data + 16'h1) : smp.data;
   assign thr      = alcpl_pkg::level_thr(st.cfg2[alcpl_pkg::LVL_LSB +: 4]);  // RQ11
   assign above    = smp.valid && (abs_val > thr);                            // RQ1
   assign zc       = smp.valid && ((smp.data[15] != st.last_sign) || (smp.data == 16'h0));
   assign weight   = {20'h0, alcpl_pkg::sr_weight(st.cfg4[alcpl_pkg::SR_LSB +: 3])}; // RQ15
   assign acc_inc  = (st.acc > alcpl_pkg::ACC_MAX - weight) ? alcpl_pkg::ACC_MAX :
                     st.acc + weight;
   assign hold_inc = (st.hold_acc > alcpl_pkg::ACC_MAX - weight) ? alcpl_pkg::ACC_MAX :
                     st.hold_acc + weight;

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      logic        aw_now;
      logic        w_now;
      logic [7:0]  widx;
      logic [15:0] wd;
      logic [1:0]  ws;
      logic [15:0] merged;
      logic        step_go;
      next_st = st;
      aw_now  = st.aw_held || (awvalid && st.awready);
      w_now   = st.w_held || (wvalid && st.wready);
      widx    = st.aw_held ? st.aw_idx : awaddr[9:2];
      wd      = st.w_held ? st.w_data : wdata[15:0];
      ws      = st.w_held ? st.w_strb : wstrb[1:0];
      merged  = 16'h0;
      step_go = 1'b0;

      // Write channel
      if (awvalid && st.awready) begin
         next_st.awready = 1'b0;
         next_st.aw_held = 1'b1;
         next_st.aw_idx  = awaddr[9:2];
      end
      if (wvalid && st.wready) begin
         next_st.wready = 1'b0;
         next_st.w_held = 1'b1;
         next_st.w_data = wdata[15:0];
         next_st.w_strb = wstrb[1:0];
      end
      if (aw_now && w_now && !st.bvalid) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.awready = 1'b0;
         next_st.wready  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = alcpl_pkg::RESP_OKAY;
         unique case (widx)
            alcpl_pkg::IDX_CFG1: merged = {7'h0, st.cfg1};
            alcpl_pkg::IDX_CFG2: merged = {7'h0, st.cfg2};
            alcpl_pkg::IDX_CFG3: merged = {7'h0, st.cfg3};
            alcpl_pkg::IDX_CFG4: merged = {2'h0, st.cfg4};
            default:             merged = 16'h0;
         endcase
         if (ws[0]) begin
            merged[7:0] = wd[7:0];
         end
         if (ws[1]) begin
            merged[15:8] = wd[15:8];
         end
         unique case (widx)
            alcpl_pkg::IDX_CFG1: next_st.cfg1 = merged[8:0];
            alcpl_pkg::IDX_CFG2: next_st.cfg2 = merged[8:0];
            alcpl_pkg::IDX_CFG3: next_st.cfg3 = merged[8:0];
            alcpl_pkg::IDX_CFG4: next_st.cfg4 = {merged[13:8], 5'h0, merged[2:0]};
            default:             next_st.bresp = alcpl_pkg::RESP_SLVERR;
         endcase
      end
      if (st.bvalid && bready) begin
         next_st.bvalid  = 1'b0;
         next_st.awready = 1'b1;
         next_st.wready  = 1'b1;
      end

      // Read channel
      if (arvalid && st.arready) begin
         next_st.arready = 1'b0;
         next_st.rvalid  = 1'b1;
         next_st.rresp   = alcpl_pkg::RESP_OKAY;
         unique case (araddr[9:2])
            alcpl_pkg::IDX_CFG1: next_st.rdata = {23'h0, st.cfg1};
            alcpl_pkg::IDX_CFG2: next_st.rdata = {23'h0, st.cfg2};
            alcpl_pkg::IDX_CFG3: next_st.rdata = {23'h0, st.cfg3};
            alcpl_pkg::IDX_CFG4: next_st.rdata = {18'h0, st.cfg4};
            alcpl_pkg::IDX_STAT: next_st.rdata = {22'h0, st.state, 2'h0, st.gain};
            default: begin
               next_st.rdata = 32'h0;
               next_st.rresp = alcpl_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (st.rvalid && rready) begin
         next_st.rvalid  = 1'b0;
         next_st.arready = 1'b1;
      end

      // Gain control
      if (smp.valid) begin
         next_st.last_sign = smp.data[15];
      end
      if (!gain_ctrl_enable) begin                                            // RQ4
         next_st.state    = alcpl_pkg::ST_IDLE;
         next_st.gain     = static_gain;
         next_st.acc      = 24'h0;
         next_st.hold_acc = 24'h0;
         next_st.pend_up  = 1'b0;
         next_st.pend_dn  = 1'b0;
      end else begin
         if (smp.valid) begin
            next_st.acc      = acc_inc;
            next_st.hold_acc = hold_inc;
         end
         step_go = (st.pend_up || st.pend_dn) && (!zero_cross_update || zc);  // RQ16
         if (st.gain > gain_ceiling) begin                                    // RQ5
            next_st.gain = gain_ceiling;
         end else if (st.gain < gain_floor) begin
            next_st.gain = gain_floor;
         end else if (step_go) begin
            next_st.pend_up = 1'b0;
            next_st.pend_dn = 1'b0;
            if (st.pend_dn && st.gain > gain_floor) begin                     // RQ1
               next_st.gain = st.gain - 6'h1;
            end else if (st.pend_up && st.gain < gain_top) begin              // RQ3
               next_st.gain = st.gain + 6'h1;
            end
         end
         unique case (st.state)
            alcpl_pkg::ST_IDLE: begin
               next_st.state = alcpl_pkg::ST_HOLD;
               next_st.acc   = 24'h0;
            end
            alcpl_pkg::ST_ATTACK: begin
               if (st.acc >= atk_len) begin                                   // RQ13
                  next_st.pend_dn = 1'b1;
                  next_st.pend_up = 1'b0;
                  next_st.acc     = 24'h0;
               end
               if (smp.valid && !above) begin
                  next_st.state    = alcpl_pkg::ST_HOLD;
                  next_st.hold_acc = 24'h0;
                  next_st.acc      = 24'h0;
               end
            end
            alcpl_pkg::ST_HOLD: begin
               if (limiter_mode_select || st.hold_acc >= hold_len) begin      // RQ9
                  next_st.state = alcpl_pkg::ST_DECAY;
                  next_st.acc   = 24'h0;
               end
            end
            alcpl_pkg::ST_DECAY: begin
               if (st.acc >= dcy_len) begin                                   // RQ17
                  next_st.pend_up = 1'b1;
                  next_st.pend_dn = 1'b0;
                  next_st.acc     = 24'h0;
               end
            end
         endcase
         if (above) begin                                                     // RQ10
            next_st.state    = alcpl_pkg::ST_ATTACK;
            next_st.hold_acc = 24'h0;
            next_st.pend_up  = 1'b0;
            if (st.state != alcpl_pkg::ST_ATTACK) begin
               next_st.acc = 24'h0;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st         <= '0;
         st.cfg1    <= alcpl_pkg::CFG1_RST;
         st.cfg2    <= alcpl_pkg::CFG2_RST;
         st.cfg3    <= alcpl_pkg::CFG3_RST;
         st.cfg4    <= alcpl_pkg::CFG4_RST;
         st.state   <= alcpl_pkg::ST_IDLE;
         st.awready <= 1'b1;
         st.wready  <= 1'b1;
         st.arready <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign awready   = st.awready;
   assign wready    = st.wready;
   assign bvalid    = st.bvalid;
   assign bresp     = st.bresp;
   assign arready   = st.arready;
   assign rvalid    = st.rvalid;
   assign rdata     = st.rdata;
   assign rresp     = st.rresp;
   assign gain_code = st.gain;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   logic in_range;
   assign in_range = (st.gain >= gain_floor) && (st.gain <= gain_ceiling);

   sequence aw_w_taken;
      awvalid && st.awready && wvalid && st.wready && !st.bvalid;
   endsequence
   sequence b_waiting;
      st.bvalid && !bready;
   endsequence

   chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      aw_w_taken |=> st.bvalid) else $error("write not answered next cycle");
   chk_bresp_stable: assert property (@(posedge aclk) disable iff (!aresetn)
      b_waiting |=> st.bvalid && $stable(st.bresp)) else $error("write answer dropped");
   chk_off_static: assert property (@(posedge aclk) disable iff (!aresetn) // RQ4
      !gain_ctrl_enable |=> st.gain == $past(static_gain)) else $error("gain not static");
   chk_limit_attack: assert property (@(posedge aclk) disable iff (!aresetn) // RQ1
      (gain_ctrl_enable && limiter_mode_select && above) |=> st.state == alcpl_pkg::ST_ATTACK)
      else $error("limiter missed peak");
   chk_level_attack: assert property (@(posedge aclk) disable iff (!aresetn) // RQ10
      (gain_ctrl_enable && !limiter_mode_select && above) |=> st.state == alcpl_pkg::ST_ATTACK)
      else $error("attack delayed");
   chk_one_step: assert property (@(posedge aclk) disable iff (!aresetn) // RQ17
      (gain_ctrl_enable && $past(gain_ctrl_enable) && $past(in_range) && $changed(st.gain))
      |-> (st.gain == 6'($past(st.gain) + 6'h1) || st.gain == 6'($past(st.gain) - 6'h1)))
      else $error("gain moved more than one step");
   chk_ceiling_rise: assert property (@(posedge aclk) disable iff (!aresetn) // RQ6
      ($past(gain_ctrl_enable) && gain_ctrl_enable && st.gain > $past(st.gain))
      |-> $past(st.gain) < $past(gain_ceiling)) else $error("gain rose past ceiling");
   chk_floor_fall: assert property (@(posedge aclk) disable iff (!aresetn) // RQ7
      ($past(gain_ctrl_enable) && $past(in_range) && st.gain < $past(st.gain))
      |-> $past(st.gain) > $past(gain_floor)) else $error("gain fell past floor");
   chk_limiter_cap: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
      ($past(gain_ctrl_enable) && $past(limiter_mode_select) && $past(in_range)
       && st.gain > $past(st.gain)) |-> $past(st.gain) < $past(static_gain))
      else $error("limiter raised gain past static level");
   chk_hold_wait: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
      (st.state == alcpl_pkg::ST_DECAY && $past(st.state) == alcpl_pkg::ST_HOLD
       && !$past(limiter_mode_select)) |-> $past(st.hold_acc) >= $past(hold_len))
      else $error("ramp-up before hold expired");
   chk_zc_only: assert property (@(posedge aclk) disable iff (!aresetn) // RQ16
      ($past(gain_ctrl_enable) && $past(zero_cross_update) && $past(in_range)
       && $changed(st.gain)) |-> $past(zc)) else $error("gain changed off zero crossing");

endmodule : alcpl_core

// ===== verification/alcpl_adc_model.sv
// Purpose: Sample source standing in for the converter feeding the gain controller
// Assumes: One sample per clock, sign alternates when asked
// Notes:   Valid low while in reset
`timescale 1ns/1ps
module alcpl_adc_model (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [15:0]      amp,
   input  wire logic             alt_sign,
   output alcpl_pkg::alcpl_sample_t smp
);
   logic neg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         smp <= '0;
         neg <= 1'b0;
      end else begin
         neg       <= alt_sign ? ~neg : 1'b0;
         smp.valid <= 1'b1;
         smp.data  <= (alt_sign && neg) ? (~amp + 16'h0001) : amp;
      end
   end
endmodule : alcpl_adc_model

// ===== verification/test_input_alc_peak_limiter.sv
// Purpose: Self-checking bench for the record-path gain controller
// Assumes: Registers reached over AXI4-Lite, one sample per clock
// Notes:   Register rows first, then hand-written gain scenarios
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
   $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module test_input_alc_peak_limiter;
   typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic [1:0] r;}
      alcpl_row_t;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, d;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, alt_sign = 1'b0;
   logic [1:0]  bresp, rresp, r;
   logic [15:0] amp = '0;
   logic [5:0]  gain_code, gmin, gmax, g0;
   int          error_cnt = 0, comparisons = 0;
   alcpl_pkg::alcpl_sample_t smp;
   alcpl_row_t  rows [9] = '{'{1'b0, 12'h080, 32'h0, 32'h038, 2'h0},
      '{1'b0, 12'h084, 32'h0, 32'h00b, 2'h0}, '{1'b0, 12'h088, 32'h0, 32'h032, 2'h0},
      '{1'b0, 12'h08c, 32'h0, 32'h1000, 2'h0}, '{1'b0, 12'h090, 32'h0, 32'h010, 2'h0},
      '{1'b1, 12'h08c, 32'hffff, 32'h3f07, 2'h0}, '{1'b1, 12'h080, 32'h0ff, 32'h0ff, 2'h0},
      '{1'b1, 12'h084, 32'h1ff, 32'h1ff, 2'h0}, '{1'b1, 12'h0fc, 32'h1ff, 32'h0, 2'h2}};

   always #50 aclk = ~aclk;

   alcpl_core #(.AXI_ADDR_W(12)) DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .smp(smp), .gain_code(gain_code));
   alcpl_adc_model adc (.aclk(aclk), .aresetn(aresetn), .amp(amp), .alt_sign(alt_sign),
      .smp(smp));

   // -----------------------------------------------------------------
   // Bus and run helpers
   // -----------------------------------------------------------------
   task summarize;
      if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize

   task wr(input logic [11:0] a, input logic [31:0] dv, output logic [1:0] rs);
      int n;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= dv;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      rs = bresp;
      bready <= 1'b0;
      if (n == 20) begin
         error_cnt++;
         summarize();
      end
   endtask : wr

   task rd(input logic [11:0] a, output logic [31:0] dv, output logic [1:0] rs);
      int n;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      dv = rdata;
      rs = rresp;
      rready <= 1'b0;
      if (n == 20) begin
         error_cnt++;
         summarize();
      end
   endtask : rd

   task watch(input int n);
      gmin = gain_code;
      gmax = gain_code;
      repeat (n) begin
         @(posedge aclk);
         if (gain_code > gmax) gmax = gain_code;
         if (gain_code < gmin) gmin = gain_code;
      end
   endtask : watch

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      watch(2);
      `CHK(gain_code, 6'h10)
      foreach (rows[i]) begin
         if (rows[i].w) begin
            wr(rows[i].a, rows[i].d, r);
            `CHK(r, rows[i].r)
         end
         rd(rows[i].a, d, r);
         `CHK({d, r}, {rows[i].x, rows[i].r})
      end
      // Level mode: rise to ceiling, fall to floor, hold before rising
      wr(12'h08c, 32'h1000, r);
      wr(12'h088, 32'h000, r);
      wr(12'h084, 32'h00b, r);
      amp      <= 16'h0100;
      alt_sign <= 1'b1;
      wr(12'h080, 32'h11a, r);
      watch(600);
      `CHK({gain_code, gmax}, {6'h1f, 6'h1f})
      wr(12'h084, 32'h01b, r);
      amp <= 16'h7000;
      watch(12);
      `CHK(gain_code < 6'h1f, 1'b1)
      watch(200);
      `CHK({gain_code, gmin}, {6'h10, 6'h10})
      amp <= 16'h0100;
      watch(100);
      `CHK(gain_code, 6'h10)
      watch(500);
      `CHK(gain_code, 6'h1f)
      // Limiter: fast attack, restore to static level, hold ignored
      wr(12'h084, 32'h0fb, r);
      wr(12'h088, 32'h100, r);
      wr(12'h080, 32'h118, r);
      amp <= 16'h7000;
      watch(50);
      `CHK(gain_code <= 6'h0b, 1'b1)
      amp <= 16'h0100;
      watch(150);
      `CHK({gain_code, gmax}, {6'h10, 6'h10})
      // Zero-cross gating
      wr(12'h088, 32'h000, r);
      alt_sign <= 1'b0;
      amp      <= 16'h7000;
      wr(12'h084, 32'h10b, r);
      g0 = gain_code;
      watch(60);
      `CHK(gain_code, g0)
      alt_sign <= 1'b1;
      watch(30);
      `CHK(gain_code < g0, 1'b1)
      wr(12'h080, 32'h018, r);
      watch(2);
      `CHK(gain_code, 6'h10)
      // Mid-run reset: gain cleared, first register back to its reset value
      aresetn <= 1'b0;
      watch(2);
      `CHK(gain_code, 6'h00)
      aresetn <= 1'b1;
      rd(12'h080, d, r);
      `CHK({d, r}, {32'h038, 2'h0})
      summarize();
   end
endmodule : test_input_alc_peak_limiter
